// file: rtl/glass_display.sv
// segment glass phase, display mode and blink control with an apb register file
// assumes base_tick and timebase_tick are pclk-wide pulses from the glass clock logic
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module glass_display
    import glass_pkg::*;
#(
    parameter int PINS = 8, // glass pins served
    parameter int BLINK_DIV = BLINK_BASE_DIV // blink divider at rate 0
)(
    input wire logic pclk, // apb and logic clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic base_tick, // phase sequencer tick
    input wire logic timebase_tick, // glass timebase tick
    output logic [PINS-1:0] pin_drive, // backplane active or segment on
    output logic [PINS-1:0] pin_backplane, // pin acts as backplane
    output logic [PINS-1:0] pin_on, // pin enabled toward the glass
    output logic [2:0] phase_out, // phase being driven, 0 is A
    output logic blink_out // blink period is being shown
);
    display_cfg_s cfg;
    logic [7:0] pin_enable_low;
    logic [7:0] backplane_select_low;
    logic [7:0] pin_phase_segment_bytes [PINS];
    display_mode_e shown_mode;
    display_mode_e next_mode;
    logic shown_blink;
    logic [2:0] seq_phase;
    logic frame_end;
    logic blink_period;

    // apb decode
    logic setup_phase;
    logic access_done;
    logic wr_en;
    logic sel_ctrl;
    logic sel_flash;
    logic sel_pen;
    logic sel_bps;
    logic sel_stat;
    logic sel_byte;
    logic mapped;
    logic [2:0] byte_idx;
    logic [31:0] next_rdata;

    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready;
    assign wr_en = access_done && pwrite && mapped;
    assign sel_ctrl = paddr == OFS_GLASS_CONTROL_ZERO;
    assign sel_flash = paddr == OFS_FLASH_CONTROL;
    assign sel_pen = paddr == OFS_PIN_ENABLE_LOW;
    assign sel_bps = paddr == OFS_BACKPLANE_SELECT_LOW;
    assign sel_stat = paddr == OFS_STATUS;
    assign sel_byte = paddr >= OFS_PHASE_SEGMENT_BASE && paddr <= OFS_PHASE_SEGMENT_LAST
        && paddr[1:0] == 2'h0 && int'(paddr[4:2]) < PINS;
    assign byte_idx = paddr[4:2];
    assign mapped = sel_ctrl || sel_flash || sel_pen || sel_bps || sel_stat || sel_byte;

    // read mux, status shows live mode, blink period and phase
    assign next_rdata = sel_ctrl ? {29'h0, cfg.duty} :
        sel_flash ? {25'h0, cfg.flash_rate, cfg.flash_style, cfg.flash_en, cfg.alt, cfg.blank} :
        sel_pen ? {24'h0, pin_enable_low} :
        sel_bps ? {24'h0, backplane_select_low} :
        sel_stat ? {26'h0, shown_mode == MODE_BLANK, shown_mode == MODE_ALT, shown_blink,
            seq_phase} :
        sel_byte ? {24'h0, pin_phase_segment_bytes[byte_idx]} : 32'h0;

    // zero-wait answer: ready and data registered during setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase && !mapped;
            prdata <= setup_phase && !pwrite ? next_rdata : 32'h0;
        end
    end

    // control registers, multiplex field holds duty 000..111
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= '{duty: RST_DUTY, flash_rate: 3'h0, default: 1'b0};
            pin_enable_low <= RST_BYTE;
            backplane_select_low <= RST_BYTE;
        end else if (wr_en) begin
            if (sel_ctrl) begin
                cfg.duty <= pwdata[2:0];
            end
            if (sel_flash) begin
                cfg.blank <= pwdata[FLD_BLANK];
                cfg.alt <= pwdata[FLD_ALT];
                cfg.flash_en <= pwdata[FLD_FLASH_EN];
                cfg.flash_style <= pwdata[FLD_FLASH_STYLE];
                cfg.flash_rate <= pwdata[FLD_FLASH_RATE +: 3];
            end
            if (sel_pen) begin
                pin_enable_low <= pwdata[7:0];
            end
            if (sel_bps) begin
                backplane_select_low <= pwdata[7:0];
            end
        end
    end

    // phase and segment bytes, one per pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < PINS; i++) begin
                pin_phase_segment_bytes[i] <= RST_BYTE;
            end
        end else if (wr_en && sel_byte) begin
            pin_phase_segment_bytes[byte_idx] <= pwdata[7:0];
        end
    end

    glass_phase_seq u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .base_tick(base_tick),
        .duty(cfg.duty),
        .phase(seq_phase),
        .frame_end(frame_end)
    );

    glass_blink_div #(.BASE_DIV(BLINK_DIV)) u_blink (
        .pclk(pclk),
        .presetn(presetn),
        .timebase_tick(timebase_tick),
        .enable(cfg.flash_en),
        .rate(cfg.flash_rate),
        .blink_period(blink_period)
    );

    // mode wanted for the coming frame
    logic big;
    logic in_blink;
    display_mode_e base_mode;
    display_mode_e blink_mode;

    assign big = is_big(cfg.duty);
    assign in_blink = cfg.flash_en && blink_period;
    assign base_mode = cfg.blank ? MODE_BLANK :
        cfg.alt ? (big ? MODE_BLANK : MODE_ALT) : MODE_NORMAL;
    assign blink_mode = cfg.flash_style && !big ? MODE_ALT : MODE_BLANK;
    assign next_mode = in_blink ? blink_mode : base_mode;

    // latch mode only between frames
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shown_mode <= MODE_NORMAL;
            shown_blink <= 1'b0;
        end else if (frame_end) begin
            shown_mode <= next_mode;
            shown_blink <= in_blink;
        end
    end

    // phase whose bits are looked at; alternate image starts at E
    logic [2:0] eff_phase;
    logic [PINS-1:0] phase_bits;
    logic [PINS-1:0] next_drive;

    assign eff_phase = shown_mode == MODE_ALT ? (seq_phase | ALT_PHASE_OFS) : seq_phase;

    // one bit per pin, segment on for fronts, active for backs
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            phase_bits[i] = pin_phase_segment_bytes[i][eff_phase];
        end
    end

    // blank clears every pin, otherwise drive from the bytes
    always_comb begin
        next_drive = '0;
        unique case (shown_mode)
            MODE_NORMAL, MODE_ALT: next_drive = phase_bits & pin_enable_low[PINS-1:0];
            MODE_BLANK: next_drive = '0;
        endcase
    end

    // registered pin outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_drive <= '0;
            pin_backplane <= '0;
            pin_on <= '0;
            phase_out <= 3'h0;
            blink_out <= 1'b0;
        end else begin
            pin_drive <= next_drive;
            pin_backplane <= backplane_select_low[PINS-1:0] & pin_enable_low[PINS-1:0];
            pin_on <= pin_enable_low[PINS-1:0];
            phase_out <= eff_phase;
            blink_out <= shown_blink;
        end
    end

    // pins stay dark through a blank frame
    property p_blank_off;
        @(posedge pclk) disable iff (!presetn)
        shown_mode == MODE_BLANK |=> pin_drive == '0;
    endproperty
    a_blank_off: assert property (p_blank_off)
        else $error("segment driven while blank");

    // pin 0 follows its own phase bit in normal frames
    property p_normal_bit;
        @(posedge pclk) disable iff (!presetn)
        shown_mode == MODE_NORMAL && pin_enable_low[0]
        |=> pin_drive[0] == $past(pin_phase_segment_bytes[0][seq_phase]);
    endproperty
    a_normal_bit: assert property (p_normal_bit)
        else $error("pin 0 does not follow its phase bit");

    // alternate frames look four phases higher
    property p_alt_bit;
        @(posedge pclk) disable iff (!presetn)
        shown_mode == MODE_ALT && pin_enable_low[1]
        |=> pin_drive[1] == $past(pin_phase_segment_bytes[1][seq_phase | ALT_PHASE_OFS]);
    endproperty
    a_alt_bit: assert property (p_alt_bit)
        else $error("alternate image not taken from upper phases");

    // alternate with five or more backplanes falls back to blank
    property p_big_alt_blank;
        @(posedge pclk) disable iff (!presetn)
        frame_end && !cfg.blank && cfg.alt && is_big(cfg.duty) && !cfg.flash_en
        |=> shown_mode == MODE_BLANK;
    endproperty
    a_big_alt_blank: assert property (p_big_alt_blank)
        else $error("alternate shown with five or more backplanes");

    // mode and blink period hold for the whole frame
    property p_frame_only;
        @(posedge pclk) disable iff (!presetn)
        !frame_end |=> $stable(shown_mode) && $stable(shown_blink);
    endproperty
    a_frame_only: assert property (p_frame_only)
        else $error("mode changed inside a frame");

    // no blink frame while flashing is off
    property p_no_flash;
        @(posedge pclk) disable iff (!presetn)
        frame_end && !cfg.flash_en |=> !shown_blink;
    endproperty
    a_no_flash: assert property (p_no_flash)
        else $error("blink period shown while flashing off");

    // blank style or a large multiplex blinks to a dark frame
    property p_blink_style;
        @(posedge pclk) disable iff (!presetn)
        frame_end && cfg.flash_en && blink_period && (!cfg.flash_style || is_big(cfg.duty))
        |=> shown_mode == MODE_BLANK ##1 pin_drive == '0;
    endproperty
    a_blink_style: assert property (p_blink_style)
        else $error("blink period not blank");

    // every setup gets exactly one ready cycle
    property p_apb_answer;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("apb answer not one access cycle");

    // backplane outputs mirror select and enable
    property p_bp_map;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> pin_backplane == $past(backplane_select_low[PINS-1:0] & pin_enable_low[PINS-1:0]);
    endproperty
    a_bp_map: assert property (p_bp_map)
        else $error("backplane select not reflected");


    c_alt: cover property (@(posedge pclk) disable iff (!presetn) shown_mode == MODE_ALT);
    c_blink: cover property (@(posedge pclk) disable iff (!presetn) $rose(shown_blink));
    c_blank: cover property (@(posedge pclk) disable iff (!presetn) shown_mode == MODE_BLANK);
    c_err: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
endmodule

// file: rtl/glass_pkg.sv
// constants, types and helpers shared by the segment glass display logic
// assumes one pclk domain; glass timebase and phase ticks arrive as pclk-wide pulses
package glass_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_GLASS_CONTROL_ZERO = 8'h00;
    localparam logic [7:0] OFS_FLASH_CONTROL = 8'h04;
    localparam logic [7:0] OFS_PIN_ENABLE_LOW = 8'h08;
    localparam logic [7:0] OFS_BACKPLANE_SELECT_LOW = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_PHASE_SEGMENT_BASE = 8'h20;
    localparam logic [7:0] OFS_PHASE_SEGMENT_LAST = 8'h3C;
    // field positions of the flash control register
    localparam int FLD_BLANK = 0;
    localparam int FLD_ALT = 1;
    localparam int FLD_FLASH_EN = 2;
    localparam int FLD_FLASH_STYLE = 3;
    localparam int FLD_FLASH_RATE = 4;
    // values after reset
    localparam logic [2:0] RST_DUTY = 3'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // blink divider: full cycle 4096 timebase ticks at rate 0, half of it per period
    localparam int BLINK_BASE_DIV = 4096;
    localparam int BLINK_CNT_W = 20;
    // alternate image lives four phases above the normal one
    localparam logic [2:0] ALT_PHASE_OFS = 3'h4;
    localparam logic [2:0] BIG_DUTY_MIN = 3'h4;

    typedef enum {MODE_NORMAL, MODE_ALT, MODE_BLANK} display_mode_e;

    typedef struct packed {
        logic blank;
        logic alt;
        logic flash_en;
        logic flash_style;
        logic [2:0] flash_rate;
        logic [2:0] duty;
    } display_cfg_s;

    // five or more backplanes: alternate image not available
    function automatic logic is_big(input logic [2:0] duty);
        return duty >= BIG_DUTY_MIN;
    endfunction
endpackage

// file: rtl/glass_phase_seq.sv
// phase sequencer: one phase per base tick, wraps after the last enabled phase
// assumes base_tick is a one-pclk pulse at frame rate times phase count
`timescale 1ns/10ps
module glass_phase_seq
    import glass_pkg::*;
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic base_tick, // base clock tick pulse
    input wire logic [2:0] duty, // multiplex field, phases minus one
    output logic [2:0] phase, // current phase, 0 is A
    output logic frame_end // pulse on the tick that closes a frame
);
    logic last_phase;

    // frame closes on the last enabled phase, or if duty shrank under us
    assign last_phase = phase >= duty;
    assign frame_end = base_tick && last_phase;

    // advance one phase per tick, starting at A
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 3'h0;
        end else if (frame_end) begin
            phase <= 3'h0;
        end else if (base_tick) begin
            phase <= phase + 3'h1;
        end
    end

    // the tick on the last enabled phase brings phase A back
    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        base_tick && phase == duty |=> phase == 3'h0;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("phase did not wrap after last phase");
endmodule

// file: rtl/glass_blink_div.sv
// blink divider: toggles the blink period every half blink cycle
// assumes timebase_tick is a one-pclk pulse at the glass timebase rate
`timescale 1ns/10ps
module glass_blink_div
    import glass_pkg::*;
#(
    parameter int BASE_DIV = BLINK_BASE_DIV // divider at rate setting 0
)(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic timebase_tick, // glass timebase tick
    input wire logic enable, // flashing enabled
    input wire logic [2:0] rate, // flash rate setting
    output logic blink_period // high during the blink half
);
    localparam logic [BLINK_CNT_W-1:0] HALF_BASE = BLINK_CNT_W'(BASE_DIV / 2);
    logic [BLINK_CNT_W-1:0] count;
    logic [BLINK_CNT_W-1:0] half_len;
    logic half_done;

    // each rate step doubles the divider
    assign half_len = HALF_BASE << rate;
    assign half_done = timebase_tick && count >= half_len - BLINK_CNT_W'(1);

    // count timebase ticks, flip period at each half
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            blink_period <= 1'b0;
        end else if (!enable) begin
            count <= '0;
            blink_period <= 1'b0;
        end else if (half_done) begin
            count <= '0;
            blink_period <= !blink_period;
        end else if (timebase_tick) begin
            count <= count + BLINK_CNT_W'(1);
        end
    end

    // blink period flips on the tick that closes a half
    property p_half_toggle;
        @(posedge pclk) disable iff (!presetn)
        enable && timebase_tick && count == half_len - BLINK_CNT_W'(1)
        |=> blink_period != $past(blink_period);
    endproperty
    a_half_toggle: assert property (p_half_toggle)
        else $error("blink period did not flip at half cycle");
    // no flip while the half is still running
    property p_no_early_toggle;
        @(posedge pclk) disable iff (!presetn)
        enable && $stable(rate) && count < half_len - BLINK_CNT_W'(1)
        |=> $stable(blink_period);
    endproperty
    a_no_early_toggle: assert property (p_no_early_toggle)
        else $error("blink period flipped early");
endmodule

// file: tb/glass_panel_model.sv
// glass panel seen from the display pins: which segments light up
// assumes pins not enabled float and light nothing
`timescale 1ns/10ps
module glass_panel_model #(
    parameter int PINS = 8 // glass pins wired
)(
    input wire logic [PINS-1:0] pin_drive, // backplane active or segment on
    input wire logic [PINS-1:0] pin_backplane, // pin acts as backplane
    input wire logic [PINS-1:0] pin_on, // pin enabled
    output logic [PINS-1:0] seg_lit, // frontplane segment energized now
    output logic bp_active // some backplane energized now
);
    // a segment lights only against an energized backplane
    assign bp_active = |(pin_drive & pin_backplane & pin_on);
    assign seg_lit = pin_drive & pin_on & ~pin_backplane & {PINS{bp_active}};
endmodule

// file: tb/glass_display_bench.sv
// self-checking bench for glass_display with a behavioural phase and blink model
// assumes zero-wait apb slave and pclk-wide tick pulses driven from here
`timescale 1ns/10ps
module glass_display_bench
    import glass_pkg::*;
;
    localparam int BLINK_DIV = 8;
    localparam int LIMIT = 20000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic base_tick, timebase_tick, blink_out, bp_active;
    logic [7:0] paddr, pin_drive, pin_backplane, pin_on, seg_lit;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] phase_out, duty, ph;
    logic [7:0] fctl, en, bp, byt[8];
    logic rerr, blank_l, alt_l, blink_l, bstate;
    int seed, checks, err_total, cyc, cnt, m, d, i, f, r;

    glass_display #(.PINS(8), .BLINK_DIV(BLINK_DIV)) i_glass_display (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .base_tick(base_tick), .timebase_tick(timebase_tick), .pin_drive(pin_drive),
        .pin_backplane(pin_backplane), .pin_on(pin_on), .phase_out(phase_out),
        .blink_out(blink_out));
    glass_panel_model #(.PINS(8)) i_glass_panel_model (.pin_drive(pin_drive),
        .pin_backplane(pin_backplane), .pin_on(pin_on), .seg_lit(seg_lit),
        .bp_active(bp_active));

    // clock and hang guard
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer; holds the request until pready is seen at a rising edge
    // only the global cycle limit ends a wait for pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // register write with shadow update of the model
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        apb(1'b1, a, {24'h0, dat});
        if (a == OFS_GLASS_CONTROL_ZERO) duty = dat[2:0];
        else if (a == OFS_FLASH_CONTROL) begin
            fctl = dat;
            if (!dat[FLD_FLASH_EN]) begin
                cnt = 0;
                bstate = 1'b0;
            end
        end
        else if (a == OFS_PIN_ENABLE_LOW) en = dat;
        else if (a == OFS_BACKPLANE_SELECT_LOW) bp = dat;
        else byt[(a - OFS_PHASE_SEGMENT_BASE) >> 2] = dat;
    endtask

    // one timebase pulse; model blink divider counts half cycles
    task automatic tb_tick();
        timebase_tick <= 1'b1;
        @(posedge pclk);
        timebase_tick <= 1'b0;
        @(posedge pclk);
        if (fctl[FLD_FLASH_EN]) begin
            cnt++;
            if (cnt == (BLINK_DIV << fctl[6:4]) / 2) begin
                cnt = 0;
                bstate = !bstate;
            end
        end
    endtask

    // one phase advance, model lookup, then compare pins and status
    task automatic tick();
        logic [7:0] e, lit;
        logic [2:0] lp;
        logic sb, sa, big;
        base_tick <= 1'b1;
        @(posedge pclk);
        base_tick <= 1'b0;
        // shown mode, multiplex size included, is chosen only at the wrap
        if (ph >= duty) begin
            ph = 3'h0;
            big = (duty >= BIG_DUTY_MIN);
            blink_l = bstate;
            if (bstate) begin
                alt_l = fctl[FLD_FLASH_STYLE] & !big;
                blank_l = !alt_l;
            end
            else begin
                blank_l = fctl[FLD_BLANK] | (fctl[FLD_ALT] & big);
                alt_l = fctl[FLD_ALT] & !blank_l;
            end
        end
        else ph = ph + 3'h1;
        sb = blank_l;
        sa = alt_l;
        lp = sa ? (ph | 3'h4) : ph;
        for (int k = 0; k < 8; k++) e[k] = en[k] & !sb & byt[k][lp];
        lit = e & en & ~bp & {8{|(e & bp & en)}};
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check("pin_drive", 32'(pin_drive), 32'(e));
        check("seg_lit", 32'(seg_lit), 32'(lit));
        check("pin_backplane", 32'(pin_backplane), 32'(bp & en));
        check("pin_on", 32'(pin_on), 32'(en));
        check("blink_out", 32'(blink_out), 32'(blink_l));
        if (!sb) check("phase_out", 32'(phase_out), 32'(lp));
        @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0);
        check("status", rd[5:3], {29'h0, sb, sa, blink_l});
    endtask

    // main sequence
    initial begin
        pclk = 0;
        presetn = 0;
        {psel, penable, pwrite, base_tick, timebase_tick} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        seed = 76;
        {checks, cnt} = '0;
        {duty, ph, fctl, en, bp} = '0;
        {blank_l, alt_l, blink_l, bstate} = 4'h0;
        for (i = 0; i < 8; i++) byt[i] = 8'h00;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values and an unmapped address
        for (i = 0; i < 13; i++) begin
            apb(1'b0, (i < 5) ? 8'(i * 4) : 8'(OFS_PHASE_SEGMENT_BASE + (i - 5) * 4), 32'h0);
            check("reset_value", rd, 32'h0);
        end
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped_err", 32'(rerr), 32'h1);
        check("unmapped_data", rd, 32'h0);
        // every multiplex value in normal, alternate and clear modes
        for (m = 0; m < 3; m++) begin
            for (d = 0; d < 8; d++) begin
                r = $random(seed);
                wr(OFS_PIN_ENABLE_LOW, (d == 7) ? 8'hFF : r[7:0]);
                wr(OFS_BACKPLANE_SELECT_LOW, (d == 7) ? 8'hFF : r[15:8]);
                for (i = 0; i < 8; i++) begin
                    r = $random(seed);
                    if (d == 7 && m == 0) r = 1 << i;
                    if (m == 1) r[7:4] = ~r[3:0];
                    wr(8'(OFS_PHASE_SEGMENT_BASE + i * 4), r[7:0]);
                end
                wr(OFS_FLASH_CONTROL, (m == 1) ? 8'h02 : (m == 2) ? 8'h01 : 8'h00);
                wr(OFS_GLASS_CONTROL_ZERO, 8'(d));
                apb(1'b0, 8'(OFS_PHASE_SEGMENT_BASE + d * 4), 32'h0);
                check("byte_readback", rd, {24'h0, byt[d]});
                repeat (2 * d + 3) tick();
            end
        end
        // flashing with both styles, two rates, small and large multiplex
        for (f = 0; f < 8; f++) begin
            wr(OFS_FLASH_CONTROL, 8'h00);
            wr(OFS_GLASS_CONTROL_ZERO, f[2] ? 8'h07 : 8'h03);
            wr(OFS_FLASH_CONTROL, {1'b0, f[1] ? 3'h2 : 3'h0, f[0], 3'b100});
            repeat (3) begin
                repeat ((BLINK_DIV << fctl[6:4]) / 2) tb_tick();
                repeat (int'(duty) + 1) tick();
            end
        end
        print_verdict();
    end
endmodule
